// File: channel_drive_diag_regs.sv
/*
  output command, resync command and collective diagnostic registers of an
  isolated eight channel switch, with the per-channel detail snapshots.
  assumes a decoded register port (one access per strobe), fault samples
  and transmit slots from the isolation link logic on the same clock, and
  an asynchronous output disable pin.

// How it works
// - each output command bit turns its channel on when one, off when zero.
// - a resync command register at 0x1c, reset zero, holds one bit a channel.
// - after a resync write its contents cross the link instead of commands.
// - each summary bit is the OR of the enabled fault flags of its channel.
// - reading the summary clears internal faults and refreshes the details.
// - in serial modes 0 and 1 every access refreshes the detail registers.
// - in serial modes 2, 3 and parallel only a summary access refreshes.
// - disable pin low forces channels off and clears the output command.
// - received faults are sticky and clear only when gone and requested.
// - address bit 7 marks a write, bit 0 is ignored.
// - after reset data-only writes go to the output command register.
*/
`timescale 1ns/10ps
`default_nettype none

module channel_drive_diag_regs #(
  parameter int channels = channel_drive_diag_pkg::num_channels
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // register port
  input wire channel_drive_diag_pkg::reg_access_t access,
  input wire logic direct_write,
  input wire logic [7:0] direct_data,
  output logic [7:0] read_data,
  output logic read_valid,
  // configuration
  input wire channel_drive_diag_pkg::iface_mode_t iface_mode,
  input wire logic [channels-1:0] diag_enable,
  input wire logic output_disable_pin_n,
  // isolation link
  input wire logic fault_valid,
  input wire channel_drive_diag_pkg::channel_faults_t [channels-1:0] faults,
  input wire logic link_slot,
  output channel_drive_diag_pkg::link_command_t link_command,
  // channel state
  output logic [channels-1:0] channel_on,
  output logic [channels-1:0] collective_fault_summary
);
  import channel_drive_diag_pkg::*;

  // ----------------------------------------------------------------
  // disable pin synchroniser
  // ----------------------------------------------------------------
  logic [2:0] dis_sync_reg;
  logic disabled_reg;
  logic disabled_next;

  assign disabled_next = (dis_sync_reg[1] == dis_sync_reg[2]) ?
                         ~dis_sync_reg[2] : disabled_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dis_sync_reg <= 3'h0;
      disabled_reg <= 1'b1;
    end else begin
      dis_sync_reg <= {dis_sync_reg[1:0], output_disable_pin_n};
      disabled_reg <= disabled_next;
    end
  end

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  function automatic logic hits(input logic [7:0] a, input logic [6:0] off);
    hits = {a[6:1], 1'b0} == off;
  endfunction : hits

  logic is_write;
  logic is_read;
  logic hit_cmd;
  logic hit_resync;
  logic hit_summary;
  logic [2:0] detail_idx;
  logic hit_detail;
  logic [6:0] acc_off;

  assign is_write = access.valid && access.addr[addr_write_bit];
  assign is_read = access.valid && !access.addr[addr_write_bit];
  assign acc_off = {access.addr[6:1], 1'b0};
  assign hit_cmd = hits(access.addr, output_command_off);
  assign hit_resync = hits(access.addr, resync_output_command_off);
  assign hit_summary = hits(access.addr, collective_fault_summary_off);
  assign hit_detail = (acc_off >= channel0_fault_detail_off) &&
                      (acc_off <= channel7_fault_detail_off);
  assign detail_idx = 3'(acc_off[6:1] - channel0_fault_detail_off[6:1]);

  // ----------------------------------------------------------------
  // write target selection
  // ----------------------------------------------------------------
  write_sel_t sel_reg;
  write_sel_t sel_next;
  logic wr_cmd;
  logic wr_resync;

  assign sel_next = (is_write && hit_resync) ? sel_resync_output_command :
                    (is_write && hit_cmd) ? sel_output_command : sel_reg;
  assign wr_cmd = (is_write && hit_cmd) ||
                  (direct_write && sel_reg == sel_output_command);
  assign wr_resync = (is_write && hit_resync) ||
                     (direct_write && sel_reg == sel_resync_output_command);

  logic [7:0] wr_value;
  assign wr_value = direct_write ? direct_data : access.wdata;

  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  logic [7:0] output_command_reg;
  logic [7:0] output_command_next;
  logic [7:0] resync_output_command_reg;
  logic resync_pending_reg;
  logic resync_pending_next;

  assign output_command_next = disabled_reg ? output_command_rst :
                               wr_cmd ? wr_value : output_command_reg;
  // a new resync write in a slot cycle stays pending
  assign resync_pending_next = wr_resync ||
                               (resync_pending_reg && !link_slot);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= sel_output_command;
      output_command_reg <= output_command_rst;
      resync_output_command_reg <= resync_output_command_rst;
      resync_pending_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      output_command_reg <= output_command_next;
      resync_pending_reg <= resync_pending_next;
      if (wr_resync) begin
        resync_output_command_reg <= wr_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // isolation link command
  // ----------------------------------------------------------------
  link_command_t link_next;
  logic [7:0] link_bits;

  assign link_bits = resync_pending_reg ? resync_output_command_reg
                                        : output_command_next;
  assign link_next.resync = resync_pending_reg;
  assign link_next.channel_on = disabled_reg ? 8'h00 : link_bits;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      link_command <= '0;
      channel_on <= '0;
    end else begin
      channel_on <= channels'(output_command_next);
      if (link_slot) begin
        link_command <= link_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky faults and detail snapshots
  // ----------------------------------------------------------------
  logic summary_read;
  logic refresh;
  logic per_access;
  channel_faults_t sticky [channels];
  logic [7:0] detail_reg [channels];
  logic [channels-1:0] summary_next;

  assign summary_read = is_read && hit_summary;
  assign per_access = (iface_mode == serial_mode0) ||
                      (iface_mode == serial_mode1);
  assign refresh = per_access ? (access.valid || direct_write)
                              : (access.valid && hit_summary);

  genvar g;
  generate
    for (g = 0; g < channels; g++) begin : g_ch
      sticky_fault_cell u_cell (
        .clock(clock),
        .arst_n(arst_n),
        .sample_valid(fault_valid),
        .sample(faults[g]),
        .clear_req(summary_read),
        .sticky(sticky[g])
      );

      assign summary_next[g] = diag_enable[g] && (|sticky[g]);

      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          detail_reg[g] <= fault_detail_rst;
        end else if (refresh) begin
          detail_reg[g] <= {3'h0, sticky[g]};
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] read_next;

  assign read_next = hit_cmd ? output_command_reg :
                     hit_resync ? resync_output_command_reg :
                     hit_summary ? 8'(summary_next) :
                     hit_detail ? detail_reg[detail_idx] : 8'h00;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      read_data <= 8'h00;
      read_valid <= 1'b0;
      collective_fault_summary <= '0;
    end else begin
      read_valid <= is_read;
      collective_fault_summary <= summary_next;
      if (is_read) begin
        read_data <= read_next;
      end
    end
  end

endmodule : channel_drive_diag_regs

`default_nettype wire

// File: channel_drive_diag_pkg.sv
/*
  shared constants and types for the channel drive and diagnostic registers.
  assumes an eight bit register port in front of it and one device clock.
*/
package channel_drive_diag_pkg;

  localparam int num_channels = 8;

  // ----------------------------------------------------------------
  // register offsets (even addresses, write flag stripped)
  // ----------------------------------------------------------------
  localparam logic [6:0] output_command_off = 7'h00;
  localparam logic [6:0] collective_fault_summary_off = 7'h02;
  localparam logic [6:0] channel0_fault_detail_off = 7'h08;
  localparam logic [6:0] channel7_fault_detail_off = 7'h16;
  localparam logic [6:0] resync_output_command_off = 7'h1c;

  // ----------------------------------------------------------------
  // address fields and reset values
  // ----------------------------------------------------------------
  localparam int addr_write_bit = 7;
  localparam logic [7:0] output_command_rst = 8'h00;
  localparam logic [7:0] resync_output_command_rst = 8'h00;
  localparam logic [7:0] fault_detail_rst = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    serial_mode0,
    serial_mode1,
    serial_mode2,
    serial_mode3,
    parallel_mode
  } iface_mode_t;

  typedef enum logic {
    sel_output_command,
    sel_resync_output_command
  } write_sel_t;

  // one addressed access from the register port
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  // fault flags of one channel as received over the isolation link
  typedef struct packed {
    logic overtemp_flag;
    logic open_load_active_flag;
    logic open_load_inactive_flag;
    logic short_to_ground_flag;
    logic short_to_supply_flag;
  } channel_faults_t;

  // command word towards the isolation link
  typedef struct packed {
    logic resync;
    logic [7:0] channel_on;
  } link_command_t;

endpackage : channel_drive_diag_pkg

// File: sticky_fault_cell.sv
/*
  sticky hold of the five fault flags of one channel.
  assumes fault samples and clear requests come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module sticky_fault_cell (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // fault samples from the link
  input wire logic sample_valid,
  input wire channel_drive_diag_pkg::channel_faults_t sample,
  // host side
  input wire logic clear_req,
  output channel_drive_diag_pkg::channel_faults_t sticky
);
  import channel_drive_diag_pkg::*;

  channel_faults_t sticky_reg;
  channel_faults_t sticky_next;
  channel_faults_t live_reg;
  channel_faults_t set_bits;
  channel_faults_t clr_bits;
  logic pending_reg;
  logic pending_next;

  // ----------------------------------------------------------------
  // set wins over clear; a bit clears only once its fault is gone
  // ----------------------------------------------------------------
  assign set_bits = sample_valid ? sample : '0;
  assign clr_bits = (pending_reg || clear_req) ? ~(set_bits | live_reg) : '0;
  assign sticky_next = (sticky_reg & ~clr_bits) | set_bits;
  // request stays armed until every bit has been allowed to clear
  assign pending_next = (pending_reg || clear_req) && (sticky_next != '0);
  assign sticky = sticky_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sticky_reg <= '0;
      live_reg <= '0;
      pending_reg <= 1'b0;
    end else begin
      sticky_reg <= sticky_next;
      pending_reg <= pending_next;
      if (sample_valid) begin
        live_reg <= sample;
      end
    end
  end

endmodule : sticky_fault_cell

`default_nettype wire

// File: channel_drive_diag_regs_chk.sv
/*
  port assertions for the channel drive and diagnostic registers.
  assumes one clock and the asynchronous active-low reset of the block.
*/
`timescale 1ns/10ps
`default_nettype none

module channel_drive_diag_regs_chk #(
  parameter int channels = channel_drive_diag_pkg::num_channels
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // register port
  input wire channel_drive_diag_pkg::reg_access_t access,
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  input wire logic direct_write,
  // configuration
  input wire logic [channels-1:0] diag_enable,
  input wire logic output_disable_pin_n,
  // link and channels
  input wire logic fault_valid,
  input wire channel_drive_diag_pkg::channel_faults_t [channels-1:0] faults,
  input wire logic link_slot,
  input wire channel_drive_diag_pkg::link_command_t link_command,
  input wire logic [channels-1:0] channel_on,
  input wire logic [channels-1:0] collective_fault_summary
);
  import channel_drive_diag_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire rd = access.valid && !access.addr[7];
  wire wr_cmd = access.valid && access.addr[7:1] == 7'h40;
  wire wr_rsy = access.valid && access.addr[7:1] == 7'h4e;

  read_answer_a: assert property (rd |=> read_valid)
    else $error("read not answered");
  answer_cause_a: assert property (!rd |=> !read_valid)
    else $error("answer without read");
  unmapped_zero_a: assert property (
    rd && access.addr[6:1] == 6'h3f |=> read_data == 8'h00)
    else $error("unmapped read not zero");
  enabled_only_a: assert property (
    1'b1 |=> (collective_fault_summary & ~$past(diag_enable)) == '0)
    else $error("disabled channel in summary");
  fault_sets_a: assert property (
    fault_valid && |faults[0] && diag_enable[0]
    |-> ##[1:3] collective_fault_summary[0])
    else $error("fault not held in summary");
  link_hold_a: assert property (!link_slot |=> $stable(link_command))
    else $error("link command moved without slot");
  off_disabled_a: assert property (
    !output_disable_pin_n [*6] |=> channel_on == '0)
    else $error("channel on while disabled");
  cmd_write_a: assert property (
    output_disable_pin_n [*6] ##0 wr_cmd
    |=> channel_on == $past(access.wdata))
    else $error("command write not on channels");
  resync_send_a: assert property (
    output_disable_pin_n [*6] ##0 wr_rsy
    ##1 (!link_slot && !wr_rsy && !direct_write) ##1 link_slot
    |=> link_command.resync && link_command.channel_on ==
    $past(access.wdata, 3))
    else $error("resync contents not sent");
endmodule : channel_drive_diag_regs_chk

bind channel_drive_diag_regs channel_drive_diag_regs_chk #(
  .channels(channels)
) i_channel_drive_diag_regs_chk (
  .clock(clock), .arst_n(arst_n), .access(access),
  .read_data(read_data), .read_valid(read_valid),
  .direct_write(direct_write),
  .diag_enable(diag_enable), .output_disable_pin_n(output_disable_pin_n),
  .fault_valid(fault_valid), .faults(faults), .link_slot(link_slot),
  .link_command(link_command), .channel_on(channel_on),
  .collective_fault_summary(collective_fault_summary)
);

`default_nettype wire

// File: host_mcu_model.sv
/*
  host controller model issuing register accesses and direct writes.
  assumes the block takes one access per strobe on the rising edge.
*/
`timescale 1ns/10ps
`default_nettype none

module host_mcu_model (
  // clock
  input wire logic clock,
  // register port
  output channel_drive_diag_pkg::reg_access_t access,
  output logic direct_write,
  output logic [7:0] direct_data,
  input wire logic [7:0] read_data,
  input wire logic read_valid
);
  import channel_drive_diag_pkg::*;
  initial begin
    access = '0;
    direct_write = 1'b0;
    direct_data = 8'h00;
  end
  // address bit 7 marks a write; released fields are scrambled
  task automatic acc(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    access <= '{valid: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    access <= '{valid: 1'b0, addr: ~a, wdata: ~d};
  endtask : acc
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    acc(a, 8'h00);
    #1;
    v = read_valid;
    d = read_data;
  endtask : rd
  task automatic dw(input logic [7:0] d);
    @(posedge clock);
    direct_write <= 1'b1;
    direct_data <= d;
    @(posedge clock);
    direct_write <= 1'b0;
    direct_data <= ~d;
  endtask : dw
endmodule : host_mcu_model

`default_nettype wire

// File: channel_drive_diag_regs_tb_top.sv
/*
  self-checking bench for the channel drive and diagnostic registers.
  assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none

module channel_drive_diag_regs_tb_top;
  import channel_drive_diag_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  reg_access_t access;
  logic direct_write, read_valid, rv;
  logic [7:0] direct_data, read_data, rdv, channel_on, summary;
  iface_mode_t iface_mode = serial_mode0;
  logic [7:0] diag_enable = 8'h7f;
  logic pin_n = 1'b1;
  logic fault_valid = 1'b0;
  logic link_slot = 1'b0;
  channel_faults_t [7:0] faults = '0;
  link_command_t link_command;
  int n_errors = 0;
  int n_tests = 0;
  always #50 clock = ~clock;

  host_mcu_model i_host_mcu_model (.clock(clock), .access(access),
    .direct_write(direct_write), .direct_data(direct_data),
    .read_data(read_data), .read_valid(read_valid));
  channel_drive_diag_regs i_channel_drive_diag_regs (.clock(clock),
    .arst_n(arst_n), .access(access), .direct_write(direct_write),
    .direct_data(direct_data), .read_data(read_data),
    .read_valid(read_valid), .iface_mode(iface_mode),
    .diag_enable(diag_enable), .output_disable_pin_n(pin_n),
    .fault_valid(fault_valid), .faults(faults), .link_slot(link_slot),
    .link_command(link_command), .channel_on(channel_on),
    .collective_fault_summary(summary));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_host_mcu_model.rd(a, rdv, rv);
    check({7'h00, rv}, 8'h01);
    check(rdv, e);
  endtask : rd_chk
  task automatic slot(input logic r, input logic [7:0] e);
    @(posedge clock) link_slot <= 1'b1;
    @(posedge clock) link_slot <= 1'b0;
    #1 check({7'h00, link_command.resync}, {7'h00, r});
    check(link_command.channel_on, e);
  endtask : slot
  task automatic pulse(input int ch, input logic [4:0] f);
    channel_faults_t [7:0] v;
    v = '0;
    v[ch] = f;
    v[7] = f;
    @(posedge clock);
    faults <= v;
    fault_valid <= 1'b1;
    @(posedge clock) fault_valid <= 1'b0;
  endtask : pulse
  task automatic wait_sum(input logic [7:0] e);
    for (int k = 0; k < 8 && summary !== e; k++) begin
      @(posedge clock);
      #1;
    end
    check(summary, e);
    if (summary !== e) begin
      tally_and_finish();
    end
  endtask : wait_sum
  task automatic tally_and_finish;
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic s_registers;
    rd_chk(8'h1c, 8'h00);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h7e, 8'h00);
  endtask : s_registers
  task automatic s_drive;
    i_host_mcu_model.acc(8'h80, 8'ha5);
    #1 check(channel_on, 8'ha5);
    rd_chk(8'h01, 8'ha5);
    i_host_mcu_model.dw(8'h3c);
    #1 check(channel_on, 8'h3c);
    slot(1'b0, 8'h3c);
  endtask : s_drive
  task automatic s_resync;
    i_host_mcu_model.acc(8'h9c, 8'h5a);
    slot(1'b1, 8'h5a);
    check(channel_on, 8'h3c);
    slot(1'b0, 8'h3c);
    rd_chk(8'h1c, 8'h5a);
    i_host_mcu_model.dw(8'h66);
    #1 check(channel_on, 8'h3c);
    slot(1'b1, 8'h66);
    rd_chk(8'h1c, 8'h66);
    i_host_mcu_model.acc(8'h80, 8'h3c);
  endtask : s_resync
  task automatic s_disable;
    @(posedge clock) pin_n <= 1'b0;
    repeat (6) @(posedge clock);
    #1 check(channel_on, 8'h00);
    i_host_mcu_model.acc(8'h80, 8'hff);
    rd_chk(8'h00, 8'h00);
    slot(1'b0, 8'h00);
    @(posedge clock) pin_n <= 1'b1;
    repeat (6) @(posedge clock);
    i_host_mcu_model.acc(8'h80, 8'h81);
    #1 check(channel_on, 8'h81);
  endtask : s_disable
  task automatic s_diag;
    iface_mode_t modes [5] = '{serial_mode0, serial_mode1, serial_mode2,
                               serial_mode3, parallel_mode};
    logic [7:0] det;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock) iface_mode <= modes[i];
      det = 8'h01 << i;
      pulse(i, det[4:0]);
      pulse(i, 5'h00);
      wait_sum(det);
      i_host_mcu_model.acc(8'h80, 8'h81);
      rd_chk(8'h08 + 8'(2 * i), (i < 2) ? det : 8'h00);
      rd_chk(8'h02, det);
      if (i > 1) rd_chk(8'h08 + 8'(2 * i), det);
      pulse(i, 5'h00);
      wait_sum(8'h00);
      rd_chk(8'h02, 8'h00);
    end
  endtask : s_diag
  task automatic s_sticky;
    pulse(0, 5'h04);
    wait_sum(8'h01);
    rd_chk(8'h02, 8'h01);
    repeat (3) @(posedge clock);
    #1 check(summary, 8'h01);
    pulse(0, 5'h00);
    wait_sum(8'h00);
  endtask : s_sticky

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    s_registers();
    s_drive();
    s_resync();
    s_disable();
    s_diag();
    s_sticky();
    tally_and_finish();
  end
endmodule : channel_drive_diag_regs_tb_top

`default_nettype wire
